// *** shared/wdtf_pkg.sv ***
/*
 watchdog with feed: shared constants, types and helpers.
 assumes one clock (cpu clock) and a special function register port from the core.
*/
// What this block does
// - underflow resets the device only when config bit 7 is set.
// - after reset the watchdog counts, run bit comes up set.
// - run bit 2 starts counting when one, stops when zero.
// - reset-enable clear: plain timer, underflow interrupt gated by the irqEnable input.
// - datapath is a 13-bit prescaler feeding an 8-bit down counter.
// - clock-select bit 0 picks watchdog oscillator when set, peripheral clock when clear.
// - underflow with reset function enabled asserts the watchdog reset.
// - watchdog reset lasts at least one selected watchdog clock cycle.
// - reset in power-down restarts oscillator, execution waits until it is stable.
// - reset-enable zero: no reset, timer usable, safety bit ignored.
// - reset-enable set, safety clear: software picks clock source freely.
// - both set: clock-select and run forced one, control and load write once.
// - control values take effect at a feed in watchdog mode; load values take effect at a feed or an underflow.
// - feed is A5 to first feed register then 5A to second.
// - no register write allowed between the two feed writes.
// - in watchdog mode an incorrect feed causes an immediate watchdog reset.
// - watchdog mode: control write must be followed directly by a feed.
// - timer mode: shadow copies control every cycle, load only through feed or underflow.
// - time-out is 2^(5+tap)*(load+1)+1 watchdog clocks.
// - time-out flag bit 1 sets on underflow, cleared by a watchdog-mode feed or zero write.
// - tap field bits 7..5 selects the prescaler tap.
// - only power-on reset returns the watchdog to its initial state.
// - clock change applies after feed (timer mode: at once): two old ticks out, two new in.
// - timer mode underflow reloads the load value and keeps counting.
// - timer mode ignores incorrect feeds.
package wdtf_pkg;
   localparam logic [7:0] ADDR_CTRL = 8'ha7;
   localparam logic [7:0] ADDR_RELOAD = 8'hb5;
   localparam logic [7:0] ADDR_FEED1 = 8'hb6;
   localparam logic [7:0] ADDR_FEED2 = 8'hb7;
   localparam logic [7:0] FEED1_KEY = 8'ha5;
   localparam logic [7:0] FEED2_KEY = 8'h5a;
   localparam int CTRL_CLK_BIT = 0;
   localparam int CTRL_TOF_BIT = 1;
   localparam int CTRL_RUN_BIT = 2;
   localparam int CTRL_PRE_LSB = 5;
   localparam int CFG_RSTEN_BIT = 7;
   localparam int CFG_SAFE_BIT = 4;
   localparam logic [2:0] PRE_RST = 3'h7;
   localparam logic [7:0] RELOAD_RST = 8'hff;
   localparam logic [3:0] PRE_BASE = 4'h5;
   localparam int PRESCALE_W = 13;
   localparam logic [1:0] SWITCH_TICKS = 2'h2;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } wdtf_sfr_req_t;

   typedef struct packed {
      logic [2:0] pre;
      logic run;
      logic clkSel;
   } wdtf_ctrl_t;

   typedef enum logic [0:0] {FEED_IDLE = 1'b0, FEED_GOT1 = 1'b1} wdtf_feed_st_t;
   typedef enum logic [1:0] {CS_RUN = 2'b00, CS_DESEL = 2'b01, CS_SEL = 2'b10} wdtf_cs_st_t;

   typedef struct packed {
      wdtf_cs_st_t st;
      logic active;
      logic [1:0] cnt;
   } wdtf_cs_state_t;

   typedef struct packed {
      wdtf_ctrl_t ctrlSfr;
      wdtf_ctrl_t shadow;
      logic [7:0] reload;
      logic [7:0] count;
      logic tof;
      wdtf_feed_st_t feedSt;
      logic mustFeed;
      logic ctrlWritten;
      logic reloadWritten;
      logic undPend;
      logic rstAct;
      logic rstTickSeen;
      logic pdLatch;
      logic pclkPh;
      logic oscPrev;
      logic [7:0] rdata;
   } wdtf_state_t;

   // last prescaler count before the counter tap fires
   function automatic logic [PRESCALE_W-1:0] tap_last(input logic [2:0] pre);
      logic [PRESCALE_W:0] one;
      one = (PRESCALE_W+1)'(1);
      tap_last = PRESCALE_W'((one << (PRE_BASE + {1'b0, pre})) - one);
   endfunction
endpackage

// *** hw/wdtf_clk_sel.sv ***
/*
 watchdog clock source switch: turns the chosen source's ticks into one tick stream.
 assumes source ticks are one-cycle pulses in the cpu clock domain.
*/
`timescale 1ns/1ns
module wdtf_clk_sel
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic selReq,
   input wire logic pclkTick,
   input wire logic oscTick,
   output logic wdTick,
   output logic activeSel
);
   wdtf_pkg::wdtf_cs_state_t state_reg;
   wdtf_pkg::wdtf_cs_state_t state_next;
   logic oldTick;
   logic newTick;

   assign oldTick = state_reg.active ? oscTick : pclkTick;
   assign newTick = selReq ? oscTick : pclkTick;
   assign activeSel = state_reg.active;
   // no ticks leave while switching, so the count pauses rather than glitches
   assign wdTick = (state_reg.st == wdtf_pkg::CS_RUN) && oldTick;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg.st)
         wdtf_pkg::CS_RUN:
         begin
            if (selReq != state_reg.active)
            begin
               state_next.st = wdtf_pkg::CS_DESEL;
               state_next.cnt = 2'h0;
            end
         end
         wdtf_pkg::CS_DESEL:
         begin
            if (oldTick)
            begin
               state_next.cnt = state_reg.cnt + 2'h1;
               if (state_reg.cnt + 2'h1 == wdtf_pkg::SWITCH_TICKS)
               begin
                  state_next.st = wdtf_pkg::CS_SEL;
                  state_next.active = selReq;
                  state_next.cnt = 2'h0;
               end
            end
         end
         wdtf_pkg::CS_SEL:
         begin
            if (oldTick)
            begin
               state_next.cnt = state_reg.cnt + 2'h1;
               if (state_reg.cnt + 2'h1 == wdtf_pkg::SWITCH_TICKS)
               begin
                  state_next.st = wdtf_pkg::CS_RUN;
               end
            end
         end
         default:
         begin
            state_next.st = wdtf_pkg::CS_RUN;
         end
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         state_reg <= '{st: wdtf_pkg::CS_RUN, active: 1'b1, cnt: 2'h0};
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // two old plus two new ticks never fit in fewer than four cycles
   property p_no_tick_switching;
      @(posedge mclk) disable iff (!rst_n)
      (state_reg.st == wdtf_pkg::CS_RUN && selReq != state_reg.active) |=> !wdTick[*4];
   endproperty
   a_no_tick_switching: assert property (p_no_tick_switching)
      else $error("watchdog tick leaked during clock switch");
endmodule

// *** hw/wdtf_prescaler.sv ***
/*
 watchdog prescaler: counts watchdog ticks, pulses at the selected tap.
 assumes tick and clear are one-cycle pulses on mclk.
*/
`timescale 1ns/1ns
module wdtf_prescaler
#(
   parameter int WIDTH = wdtf_pkg::PRESCALE_W
)
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic clear,
   input wire logic [2:0] pre,
   output logic decPulse
);
   logic [WIDTH-1:0] state_reg;
   logic [WIDTH-1:0] state_next;

   assign decPulse = tick && !clear && (state_reg == wdtf_pkg::tap_last(pre));

   always_comb
   begin
      state_next = state_reg;
      if (clear)
      begin
         state_next = '0;
      end
      else if (decPulse)
      begin
         state_next = '0;
      end
      else if (tick)
      begin
         state_next = state_reg + WIDTH'(1);
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   property p_dec_needs_tick;
      @(posedge mclk) disable iff (!rst_n)
      decPulse |-> tick && state_reg == wdtf_pkg::tap_last(pre) ##1 state_reg == '0;
   endproperty
   a_dec_needs_tick: assert property (p_dec_needs_tick)
      else $error("prescaler tap fired without its count");
endmodule

// *** hw/wdtf_top.sv ***
/*
 watchdog timer with feed sequence, reached as special function registers.
 assumes rst_n is the power-on reset only; other resets of the chip leave this block alone.
 the watchdog oscillator arrives as a synchronous level on oscIn.
*/
`timescale 1ns/1ns
module wdtf_top
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire wdtf_pkg::wdtf_sfr_req_t sfrReq,
   output logic [7:0] sfrRdata,
   input wire logic [7:0] nvCfg,
   input wire logic oscIn,
   input wire logic powerDown,
   input wire logic oscStable,
   input wire logic irqEnable,
   output logic wdtReset,
   output logic oscRestart,
   output logic irq
);
   wdtf_pkg::wdtf_state_t state_reg;
   wdtf_pkg::wdtf_state_t state_next;
   logic rstEn;
   logic lock;
   logic effRun;
   logic effClk;
   logic wrCtrl;
   logic wrReload;
   logic wrFeed1;
   logic wrFeed2;
   logic wrOther;
   logic feedDone;
   logic badFeed;
   logic pclkTick;
   logic oscTick;
   logic wdTick;
   logic decPulse;
   logic underflow;
   logic tofSet;

   assign rstEn = nvCfg[wdtf_pkg::CFG_RSTEN_BIT];
   // safety bit only counts with reset enabled
   assign lock = rstEn && nvCfg[wdtf_pkg::CFG_SAFE_BIT];
   assign effRun = state_reg.shadow.run || lock;
   assign effClk = state_reg.shadow.clkSel || lock;

   assign wrCtrl = sfrReq.wr && sfrReq.addr == wdtf_pkg::ADDR_CTRL;
   assign wrReload = sfrReq.wr && sfrReq.addr == wdtf_pkg::ADDR_RELOAD;
   assign wrFeed1 = sfrReq.wr && sfrReq.addr == wdtf_pkg::ADDR_FEED1;
   assign wrFeed2 = sfrReq.wr && sfrReq.addr == wdtf_pkg::ADDR_FEED2;
   assign wrOther = sfrReq.wr && !wrFeed1 && !wrFeed2;

   // peripheral clock is half the cpu clock and stops in power-down
   assign pclkTick = state_reg.pclkPh && !powerDown;
   assign oscTick = oscIn && !state_reg.oscPrev;
   assign underflow = decPulse && state_reg.count == 8'h00;
   assign tofSet = state_reg.undPend && wdTick;

   wdtf_clk_sel u_clk_sel
   (
      .mclk(mclk),
      .rst_n(rst_n),
      .selReq(effClk),
      .pclkTick(pclkTick),
      .oscTick(oscTick),
      .wdTick(wdTick),
      .activeSel()
   );

   wdtf_prescaler #(.WIDTH(wdtf_pkg::PRESCALE_W)) u_prescaler
   (
      .mclk(mclk),
      .rst_n(rst_n),
      .tick(wdTick && effRun),
      .clear(feedDone),
      .pre(state_reg.shadow.pre),
      .decPulse(decPulse)
   );

   always_comb
   begin
      state_next = state_reg;
      feedDone = 1'b0;
      badFeed = 1'b0;
      state_next.pclkPh = !state_reg.pclkPh;
      state_next.oscPrev = oscIn;

      // feed checker
      case (state_reg.feedSt)
         wdtf_pkg::FEED_IDLE:
         begin
            if (wrFeed1)
            begin
               if (sfrReq.wdata == wdtf_pkg::FEED1_KEY)
               begin
                  state_next.feedSt = wdtf_pkg::FEED_GOT1;
               end
               else
               begin
                  badFeed = 1'b1;
               end
            end
            else if (wrFeed2)
            begin
               badFeed = 1'b1;
            end
            else if (state_reg.mustFeed && sfrReq.wr)
            begin
               badFeed = 1'b1;
            end
         end
         wdtf_pkg::FEED_GOT1:
         begin
            if (sfrReq.wr)
            begin
               state_next.feedSt = wdtf_pkg::FEED_IDLE;
               if (wrFeed2 && sfrReq.wdata == wdtf_pkg::FEED2_KEY)
               begin
                  feedDone = 1'b1;
               end
               else
               begin
                  badFeed = 1'b1;
               end
            end
         end
         default:
         begin
            state_next.feedSt = wdtf_pkg::FEED_IDLE;
         end
      endcase

      if (feedDone || badFeed)
      begin
         state_next.mustFeed = 1'b0;
      end

      // software side of control and load
      if (wrCtrl)
      begin
         if (!(lock && state_reg.ctrlWritten))
         begin
            state_next.ctrlSfr.pre = sfrReq.wdata[wdtf_pkg::CTRL_PRE_LSB +: 3];
            state_next.ctrlSfr.run = sfrReq.wdata[wdtf_pkg::CTRL_RUN_BIT];
            state_next.ctrlSfr.clkSel = sfrReq.wdata[wdtf_pkg::CTRL_CLK_BIT];
            state_next.ctrlWritten = 1'b1;
         end
         if (!sfrReq.wdata[wdtf_pkg::CTRL_TOF_BIT])
         begin
            state_next.tof = 1'b0;
         end
         if (rstEn)
         begin
            state_next.mustFeed = 1'b1;
         end
      end
      if (wrReload && !(lock && state_reg.reloadWritten))
      begin
         state_next.reload = sfrReq.wdata;
         state_next.reloadWritten = 1'b1;
      end

      // shadow control: every cycle in timer mode, else only on a feed
      if (!rstEn)
      begin
         state_next.shadow = state_reg.ctrlSfr;
      end
      else if (feedDone)
      begin
         state_next.shadow = state_reg.ctrlSfr;
      end

      // down counter
      if (feedDone)
      begin
         state_next.count = state_reg.reload;
         state_next.undPend = 1'b0;
         if (rstEn)
         begin
            state_next.tof = 1'b0;
         end
      end
      else if (underflow)
      begin
         // reload and keep going; the extra tick before the flag gives the +1
         state_next.count = state_reg.reload;
         state_next.undPend = 1'b1;
      end
      else if (decPulse)
      begin
         state_next.count = state_reg.count - 8'h01;
      end
      if (tofSet && !underflow)
      begin
         state_next.undPend = 1'b0;
      end

      // flag set wins over any clear in the same cycle
      if (tofSet)
      begin
         state_next.tof = 1'b1;
      end

      // reset request: released on the tick that closes a whole watchdog clock period
      // after the first one, so a tick right after the raise cannot cut it short
      if (state_reg.rstAct)
      begin
         if (wdTick)
         begin
            state_next.rstTickSeen = 1'b1;
         end
         if (state_reg.rstTickSeen && wdTick && (!state_reg.pdLatch || oscStable))
         begin
            state_next.rstAct = 1'b0;
            state_next.rstTickSeen = 1'b0;
            state_next.pdLatch = 1'b0;
         end
      end
      // timer mode drops both bad feeds and underflow resets
      if (rstEn && ((tofSet) || badFeed))
      begin
         state_next.rstAct = 1'b1;
         state_next.rstTickSeen = 1'b0;
         state_next.pdLatch = state_reg.pdLatch || powerDown;
      end

      // read port
      if (sfrReq.rd)
      begin
         if (sfrReq.addr == wdtf_pkg::ADDR_CTRL)
         begin
            state_next.rdata = 8'h00;
            state_next.rdata[wdtf_pkg::CTRL_PRE_LSB +: 3] = state_reg.ctrlSfr.pre;
            state_next.rdata[wdtf_pkg::CTRL_RUN_BIT] = state_reg.ctrlSfr.run || lock;
            state_next.rdata[wdtf_pkg::CTRL_TOF_BIT] = state_reg.tof;
            state_next.rdata[wdtf_pkg::CTRL_CLK_BIT] = state_reg.ctrlSfr.clkSel || lock;
         end
         else if (sfrReq.addr == wdtf_pkg::ADDR_RELOAD)
         begin
            state_next.rdata = state_reg.reload;
         end
         else
         begin
            state_next.rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         // power-on only; the block's own reset request does not come back here
         state_reg <= '0;
         state_reg.ctrlSfr <= '{pre: wdtf_pkg::PRE_RST, run: 1'b1, clkSel: 1'b1};
         state_reg.shadow <= '{pre: wdtf_pkg::PRE_RST, run: 1'b1, clkSel: 1'b1};
         state_reg.reload <= wdtf_pkg::RELOAD_RST;
         state_reg.count <= wdtf_pkg::RELOAD_RST;
         // a high oscillator at release must not look like a fresh edge
         state_reg.oscPrev <= oscIn;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign sfrRdata = state_reg.rdata;
   assign wdtReset = state_reg.rstAct;
   assign oscRestart = state_reg.rstAct && state_reg.pdLatch;
   assign irq = state_reg.tof && !rstEn && irqEnable;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   property p_bad_feed_resets;
      badFeed && rstEn |=> wdtReset;
   endproperty
   a_bad_feed_resets: assert property (p_bad_feed_resets)
      else $error("bad feed in watchdog mode did not reset");

   property p_timer_no_reset;
      !rstEn && !wdtReset ##1 !rstEn |-> !wdtReset;
   endproperty
   a_timer_no_reset: assert property (p_timer_no_reset)
      else $error("reset raised in timer mode");

   property p_feed_loads;
      feedDone |=> state_reg.count == $past(state_reg.reload) && !state_reg.undPend;
   endproperty
   a_feed_loads: assert property (p_feed_loads)
      else $error("feed did not load the down counter");

   property p_timer_shadow;
      !rstEn |=> state_reg.shadow == $past(state_reg.ctrlSfr);
   endproperty
   a_timer_shadow: assert property (p_timer_shadow)
      else $error("timer mode shadow did not follow control");

   property p_safety_forced;
      lock && sfrReq.rd && sfrReq.addr == wdtf_pkg::ADDR_CTRL
         |=> sfrRdata[wdtf_pkg::CTRL_RUN_BIT] && sfrRdata[wdtf_pkg::CTRL_CLK_BIT];
   endproperty
   a_safety_forced: assert property (p_safety_forced)
      else $error("safety lock did not force run and clock select");

   property p_underflow_flag;
      state_reg.undPend && wdTick |=> state_reg.tof;
   endproperty
   a_underflow_flag: assert property (p_underflow_flag)
      else $error("time-out flag missing after underflow");

   property p_underflow_resets;
      tofSet && rstEn |=> wdtReset;
   endproperty
   a_underflow_resets: assert property (p_underflow_resets)
      else $error("underflow did not reset in watchdog mode");

   property p_reset_hold;
      $rose(wdtReset) |-> wdtReset[*3];
   endproperty
   a_reset_hold: assert property (p_reset_hold)
      else $error("watchdog reset shorter than a watchdog clock");

   property p_stopped_holds;
      !effRun && !feedDone |=> $stable(state_reg.count);
   endproperty
   a_stopped_holds: assert property (p_stopped_holds)
      else $error("counter moved while stopped");

   property p_irq_relation;
      irq == (state_reg.tof && !rstEn && irqEnable);
   endproperty
   a_irq_relation: assert property (p_irq_relation)
      else $error("interrupt output disagrees with flag and mode");

   property p_reload_once;
      lock && state_reg.reloadWritten && wrReload |=> $stable(state_reg.reload);
   endproperty
   a_reload_once: assert property (p_reload_once)
      else $error("locked load register took a second write");
endmodule

// *** sim/wdtf_core_model.sv ***
/*
 core model: issues special function register reads and writes to the watchdog.
 assumes it shares mclk with the block and that one task runs at a time.
*/
`timescale 1ns/1ns
module wdtf_core_model
(
   input wire logic mclk,
   output wdtf_pkg::wdtf_sfr_req_t sfrReq,
   input wire logic [7:0] sfrRdata
);
   initial sfrReq = '0;

   // released fields show inverted values so a stale address never looks valid
   task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
      @(posedge mclk);
      sfrReq <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      @(posedge mclk);
      sfrReq <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
   endtask

   task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
      @(posedge mclk);
      sfrReq <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
      @(posedge mclk);
      sfrReq <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hff};
      @(posedge mclk);
      data = sfrRdata;
   endtask

   // two writes back to back, nothing written in between
   task automatic feed();
      sfr_write(wdtf_pkg::ADDR_FEED1, wdtf_pkg::FEED1_KEY);
      sfr_write(wdtf_pkg::ADDR_FEED2, wdtf_pkg::FEED2_KEY);
   endtask
endmodule

// *** sim/tb.sv ***
/*
 testbench for the watchdog with feed: register sequences through the core model.
 assumes the core model owns the register port; the watchdog oscillator is made here.
*/
`timescale 1ns/1ns
module tb;
   logic mclk, rstN, powerDown, oscStable, irqEnable, wdtReset, oscRestart, irq;
   logic oscIn = 1'b0;
   logic [2:0] oscDiv = 3'h0;
   logic [7:0] nvCfg, sfrRdata;
   int tickCnt = 0;
   int t0, cyc, nMismatch, nTests;
   wdtf_pkg::wdtf_sfr_req_t sfrReq;

   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // oscillator at an eighth of mclk; tickCnt steps one mclk before oscIn rises
   always @(posedge mclk)
   begin
      oscDiv <= oscDiv + 3'h1;
      oscIn <= oscDiv[2];
      if (oscDiv == 3'h3)
      begin
         tickCnt <= tickCnt + 1;
      end
   end

   wdtf_top dut_u
   (
      .mclk(mclk),
      .rst_n(rstN),
      .sfrReq(sfrReq),
      .sfrRdata(sfrRdata),
      .nvCfg(nvCfg),
      .oscIn(oscIn),
      .powerDown(powerDown),
      .oscStable(oscStable),
      .irqEnable(irqEnable),
      .wdtReset(wdtReset),
      .oscRestart(oscRestart),
      .irq(irq)
   );

   wdtf_core_model core_u
   (
      .mclk(mclk),
      .sfrReq(sfrReq),
      .sfrRdata(sfrRdata)
   );

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      nTests++;
      if (seen !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
         nMismatch++;
      end
   endtask

   task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] v;
      core_u.sfr_read(addr, v);
      check("register read", v, exp);
   endtask

   // bounded wait on irq or wdtReset reaching a level
   task automatic wait_on(input bit useIrq, input logic lvl, input int lim);
      cyc = 0;
      while (((useIrq ? irq : wdtReset) !== lvl) && cyc < lim)
      begin
         @(posedge mclk);
         cyc++;
      end
      check("wait level", {7'h0, (useIrq ? irq : wdtReset) === lvl}, 8'h01);
   endtask

   // one tick of slack: the feed edge may straddle an oscillator edge
   function automatic logic [7:0] in_win(input int n);
      return (n >= 33 && n <= 34) ? 8'h01 : 8'h00;
   endfunction

   task automatic do_reset();
      @(posedge mclk);
      rstN <= 1'b0;
      repeat (8) @(posedge mclk);
      rstN <= 1'b1;
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", nTests, nMismatch);
      if (nMismatch == 0 && nTests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      #500000;
      nMismatch++;
      results();
   end

   initial
   begin
      rstN = 1'b0;
      powerDown = 1'b0;
      oscStable = 1'b1;
      irqEnable = 1'b1;
      nvCfg = 8'h00;
      nMismatch = 0;
      nTests = 0;
      do_reset();
      rd_check(wdtf_pkg::ADDR_CTRL, 8'he5);
      rd_check(8'h00, 8'h00);
      // timer mode, load 0, tap 0
      core_u.sfr_write(wdtf_pkg::ADDR_RELOAD, 8'h00);
      core_u.sfr_write(wdtf_pkg::ADDR_CTRL, 8'h05);
      core_u.feed();
      t0 = tickCnt;
      wait_on(1'b1, 1'b1, 2000);
      check("timer ticks", in_win(tickCnt - t0), 8'h01);
      check("no reset", {7'h0, wdtReset}, 8'h00);
      rd_check(wdtf_pkg::ADDR_CTRL, 8'h07);
      core_u.sfr_write(wdtf_pkg::ADDR_CTRL, 8'h05);
      rd_check(wdtf_pkg::ADDR_CTRL, 8'h05);
      check("irq cleared", {7'h0, irq}, 8'h00);
      irqEnable <= 1'b0;
      repeat (300) @(posedge mclk);
      rd_check(wdtf_pkg::ADDR_CTRL, 8'h07);
      check("irq masked", {7'h0, irq}, 8'h00);
      core_u.sfr_write(wdtf_pkg::ADDR_FEED2, wdtf_pkg::FEED2_KEY);
      repeat (4) @(posedge mclk);
      check("bad feed ignored", {7'h0, wdtReset}, 8'h00);
      core_u.sfr_write(wdtf_pkg::ADDR_CTRL, 8'h01);
      repeat (400) @(posedge mclk);
      rd_check(wdtf_pkg::ADDR_CTRL, 8'h01);
      // watchdog mode
      @(posedge mclk);
      nvCfg <= 8'h80;
      core_u.sfr_write(wdtf_pkg::ADDR_CTRL, 8'h05);
      core_u.feed();
      t0 = tickCnt;
      wait_on(1'b0, 1'b1, 2000);
      check("watchdog ticks", in_win(tickCnt - t0), 8'h01);
      t0 = tickCnt;
      wait_on(1'b0, 1'b0, 200);
      check("reset spans a tick", {7'h0, tickCnt > t0}, 8'h01);
      rd_check(wdtf_pkg::ADDR_CTRL, 8'h07);
      core_u.feed();
      rd_check(wdtf_pkg::ADDR_CTRL, 8'h05);
      core_u.sfr_write(wdtf_pkg::ADDR_FEED1, wdtf_pkg::FEED1_KEY);
      core_u.sfr_write(wdtf_pkg::ADDR_FEED2, 8'h11);
      wait_on(1'b0, 1'b1, 4);
      wait_on(1'b0, 1'b0, 200);
      core_u.sfr_write(wdtf_pkg::ADDR_CTRL, 8'h05);
      core_u.sfr_write(wdtf_pkg::ADDR_RELOAD, 8'h00);
      wait_on(1'b0, 1'b1, 4);
      wait_on(1'b0, 1'b0, 200);
      // reset raised in power-down waits for a stable oscillator
      core_u.feed();
      powerDown <= 1'b1;
      oscStable <= 1'b0;
      core_u.sfr_write(wdtf_pkg::ADDR_FEED2, 8'h00);
      wait_on(1'b0, 1'b1, 4);
      check("osc restart", {7'h0, oscRestart}, 8'h01);
      repeat (40) @(posedge mclk);
      check("reset held", {7'h0, wdtReset}, 8'h01);
      oscStable <= 1'b1;
      wait_on(1'b0, 1'b0, 20);
      powerDown <= 1'b0;
      // peripheral clock chosen: two mclk per tick, far quicker than the oscillator
      core_u.sfr_write(wdtf_pkg::ADDR_CTRL, 8'h04);
      core_u.feed();
      wait_on(1'b0, 1'b1, 400);
      check("pclk timeout", {7'h0, cyc >= 66 && cyc < 120}, 8'h01);
      wait_on(1'b0, 1'b0, 200);
      // safety lock: forced bits and write-once
      @(posedge mclk);
      nvCfg <= 8'h90;
      do_reset();
      core_u.sfr_write(wdtf_pkg::ADDR_CTRL, 8'h00);
      core_u.feed();
      rd_check(wdtf_pkg::ADDR_CTRL, 8'h05);
      core_u.sfr_write(wdtf_pkg::ADDR_CTRL, 8'he0);
      core_u.feed();
      rd_check(wdtf_pkg::ADDR_CTRL, 8'h05);
      core_u.sfr_write(wdtf_pkg::ADDR_RELOAD, 8'h10);
      core_u.sfr_write(wdtf_pkg::ADDR_RELOAD, 8'h00);
      rd_check(wdtf_pkg::ADDR_RELOAD, 8'h10);
      results();
   end
endmodule
